// ### usb_frame_counter_periodic_start.sv
// frame number counter, start-of-frame sequencing and periodic start
// threshold of the host controller's frame timing logic

// Overview of operation
// - A frame number counter register gives software and hardware a common time base.
// - The frame number steps by one whenever the frame-time-remaining counter reloads.
// - From its maximum value the frame number wraps to zero on the next step.
// - Entering the operational state steps the frame number once by itself.
// - Each frame in the operational state the number goes to the shared area after the step and the token, before the first descriptor fetch.
// - When that shared-area write completes the start-of-frame status flag is set.
// - A programmable threshold gives the earliest point of a frame for periodic work.
// - Hardware reset clears the threshold field to zero.
// - When the remaining time reaches the threshold periodic work takes priority.
// - Work in progress is not aborted; the current control or bulk transfer finishes first.
// - The frame number field sits in the low bits and is read/write, upper bits reserved zero.
// - The remaining-time counter decrements per bit time and reloads after reaching zero.
// - The frame interval setting resets to its nominal value of 11,999 bit times.
module usb_frame_counter_periodic_start (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic bit_tick,
   input wire logic operational_state,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [frame_timing_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [frame_timing_pkg::DATA_W-1:0] reg_wdata,
   input wire logic sof_sent,
   input wire logic hcca_ack,
   input wire logic start_of_frame_clear,
   input wire logic async_xfer_busy,
   output logic [frame_timing_pkg::DATA_W-1:0] reg_rdata_q,
   output logic reg_rvalid_q,
   output logic sof_req_q,
   output logic hcca_wr_q,
   output logic [frame_timing_pkg::FN_W-1:0] hcca_data_q,
   output logic start_of_frame_flag_q,
   output logic endpoint_descriptor_fetch_ok_q,
   output logic periodic_go_q,
   output logic [frame_timing_pkg::FIELD_W-1:0] frame_time_left_q
);
   logic [frame_timing_pkg::FN_W-1:0] frame_count_q;
   logic [frame_timing_pkg::FIELD_W-1:0] periodic_threshold_q;
   logic [frame_timing_pkg::FIELD_W-1:0] frame_length_setting_q;
   logic [frame_timing_pkg::FIELD_W-1:0] left_w;
   logic reload_w;
   logic oper_q;
   logic enter_oper;
   logic boundary;
   logic periodic_pending_q;
   logic [frame_timing_pkg::DATA_W-1:0] rdata_d;
   frame_timing_pkg::frame_state_e state_q;

   assign enter_oper = operational_state && !oper_q;
   assign boundary = reload_w || enter_oper;

   // interval is not software writable here; holds its reset value
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         frame_length_setting_q <= frame_timing_pkg::FRAME_INTERVAL_NOMINAL;
      end
   end

   frame_time_left_counter u_left (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .bit_tick(bit_tick),
      .restart(enter_oper),
      .frame_interval_value(frame_length_setting_q),
      .frame_time_left_q(left_w),
      .reload_q(reload_w)
   );

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         frame_time_left_q <= frame_timing_pkg::LEFT_ZERO;
      end else if (clk_en) begin
         frame_time_left_q <= left_w;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         oper_q <= 1'b0;
      end else if (clk_en) begin
         oper_q <= operational_state;
      end
   end

   // software write wins over a same-cycle hardware step
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         frame_count_q <= frame_timing_pkg::FRAME_COUNT_RST;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == frame_timing_pkg::FRAME_COUNT_OFS) begin
            frame_count_q <= {{(frame_timing_pkg::FN_W
               - frame_timing_pkg::FIELD_W){1'b0}},
               reg_wdata[frame_timing_pkg::FIELD_W-1:0]};
         end else if (boundary) begin
            if (frame_count_q == frame_timing_pkg::FRAME_COUNT_MAX) begin
               frame_count_q <= frame_timing_pkg::FRAME_COUNT_RST;
            end else begin
               frame_count_q <= frame_count_q
                  + frame_timing_pkg::FRAME_COUNT_ONE;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         periodic_threshold_q <= frame_timing_pkg::THRESHOLD_RST;
      end else if (clk_en) begin
         if (reg_wr
               && reg_addr == frame_timing_pkg::PERIODIC_THRESHOLD_OFS) begin
            periodic_threshold_q <=
               reg_wdata[frame_timing_pkg::FIELD_W-1:0];
         end
      end
   end

   // start-of-frame sequence: token, shared-area write, then flag
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= frame_timing_pkg::ST_IDLE;
      end else if (clk_en) begin
         case (state_q)
            frame_timing_pkg::ST_IDLE: begin
               if (boundary && operational_state) begin
                  state_q <= frame_timing_pkg::ST_SOF;
               end
            end
            frame_timing_pkg::ST_SOF: begin
               if (sof_sent) begin
                  state_q <= frame_timing_pkg::ST_HCCA;
               end
            end
            frame_timing_pkg::ST_HCCA: begin
               if (hcca_ack) begin
                  state_q <= frame_timing_pkg::ST_FLAG;
               end
            end
            frame_timing_pkg::ST_FLAG: begin
               state_q <= frame_timing_pkg::ST_IDLE;
            end
            default: begin
               state_q <= frame_timing_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sof_req_q <= 1'b0;
      end else if (clk_en) begin
         sof_req_q <= state_q == frame_timing_pkg::ST_IDLE
            && boundary && operational_state;
      end
   end

   // write request holds until acknowledged
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hcca_wr_q <= 1'b0;
         hcca_data_q <= frame_timing_pkg::FRAME_COUNT_RST;
      end else if (clk_en) begin
         if (state_q == frame_timing_pkg::ST_SOF && sof_sent) begin
            hcca_wr_q <= 1'b1;
            hcca_data_q <= frame_count_q;
         end else if (hcca_wr_q && hcca_ack) begin
            hcca_wr_q <= 1'b0;
         end
      end
   end

   // descriptor fetch only after the number has landed
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         endpoint_descriptor_fetch_ok_q <= 1'b0;
      end else if (clk_en) begin
         if (boundary || !operational_state) begin
            endpoint_descriptor_fetch_ok_q <= 1'b0;
         end else if (state_q == frame_timing_pkg::ST_HCCA && hcca_ack) begin
            endpoint_descriptor_fetch_ok_q <= 1'b1;
         end
      end
   end

   // set beats a same-cycle clear so no frame event is lost
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         start_of_frame_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (state_q == frame_timing_pkg::ST_HCCA && hcca_ack) begin
            start_of_frame_flag_q <= 1'b1;
         end else if (start_of_frame_clear) begin
            start_of_frame_flag_q <= 1'b0;
         end
      end
   end

   // priority latches at the threshold and lasts to the frame end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         periodic_pending_q <= 1'b0;
      end else if (clk_en) begin
         if (boundary) begin
            periodic_pending_q <= 1'b0;
         end else if (operational_state
               && left_w == periodic_threshold_q) begin
            periodic_pending_q <= 1'b1;
         end
      end
   end

   // a running control or bulk transfer is never cut short
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         periodic_go_q <= 1'b0;
      end else if (clk_en) begin
         if (boundary) begin
            periodic_go_q <= 1'b0;
         end else if (periodic_pending_q && !async_xfer_busy) begin
            periodic_go_q <= 1'b1;
         end
      end
   end

   always_comb begin
      rdata_d = frame_timing_pkg::UNMAPPED_READ;
      if (reg_addr == frame_timing_pkg::FRAME_COUNT_OFS) begin
         rdata_d[frame_timing_pkg::FIELD_W-1:0] =
            frame_count_q[frame_timing_pkg::FIELD_W-1:0];
      end else if (reg_addr == frame_timing_pkg::PERIODIC_THRESHOLD_OFS) begin
         rdata_d[frame_timing_pkg::FIELD_W-1:0] = periodic_threshold_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata_q <= frame_timing_pkg::UNMAPPED_READ;
         reg_rvalid_q <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            reg_rdata_q <= rdata_d;
         end
      end
   end
endmodule

// ### frame_timing_pkg.sv
// shared constants for the frame number and periodic start logic
package frame_timing_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int FN_W = 16;
   localparam int FIELD_W = 14;
   localparam logic [ADDR_W-1:0] FRAME_COUNT_OFS = 8'h3c;
   localparam logic [ADDR_W-1:0] PERIODIC_THRESHOLD_OFS = 8'h40;
   localparam logic [FN_W-1:0] FRAME_COUNT_RST = 16'h0000;
   localparam logic [FN_W-1:0] FRAME_COUNT_MAX = 16'hffff;
   localparam logic [FN_W-1:0] FRAME_COUNT_ONE = 16'h0001;
   localparam logic [FIELD_W-1:0] THRESHOLD_RST = 14'h0000;
   localparam logic [FIELD_W-1:0] FRAME_INTERVAL_NOMINAL = 14'h2edf;
   localparam logic [FIELD_W-1:0] LEFT_ONE = 14'h0001;
   localparam logic [FIELD_W-1:0] LEFT_ZERO = 14'h0000;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SOF = 4'b0010,
      ST_HCCA = 4'b0100,
      ST_FLAG = 4'b1000
   } frame_state_e;
endpackage

// ### frame_time_left_counter.sv
// frame-time-remaining down counter, reloads from the frame interval
module frame_time_left_counter (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic bit_tick,
   input wire logic restart,
   input wire logic [frame_timing_pkg::FIELD_W-1:0] frame_interval_value,
   output logic [frame_timing_pkg::FIELD_W-1:0] frame_time_left_q,
   output logic reload_q
);
   // counts once per bit time; zero reloads at the next bit boundary
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         frame_time_left_q <= frame_timing_pkg::LEFT_ZERO;
      end else if (clk_en) begin
         if (restart) begin
            frame_time_left_q <= frame_interval_value;
         end else if (bit_tick) begin
            if (frame_time_left_q == frame_timing_pkg::LEFT_ZERO) begin
               frame_time_left_q <= frame_interval_value;
            end else begin
               frame_time_left_q <= frame_time_left_q
                  - frame_timing_pkg::LEFT_ONE;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reload_q <= 1'b0;
      end else if (clk_en) begin
         reload_q <= bit_tick && !restart
            && frame_time_left_q == frame_timing_pkg::LEFT_ZERO;
      end
   end
endmodule

// ### usb_frame_counter_properties.sv
// checker for register answers, frame sequencing and periodic start
module frame_counter_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic reg_rd,
   input wire logic sof_sent,
   input wire logic hcca_ack,
   input wire logic start_of_frame_clear,
   input wire logic async_xfer_busy,
   input wire logic [frame_timing_pkg::DATA_W-1:0] reg_rdata_q,
   input wire logic reg_rvalid_q,
   input wire logic sof_req_q,
   input wire logic hcca_wr_q,
   input wire logic start_of_frame_flag_q,
   input wire logic endpoint_descriptor_fetch_ok_q,
   input wire logic periodic_go_q,
   input wire logic [frame_timing_pkg::FIELD_W-1:0] frame_time_left_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   chk_read_answered: assert property (clk_en && reg_rd |=> reg_rvalid_q)
      else $error("read strobe got no answer");
   chk_reserved_zero: assert property (reg_rvalid_q |-> reg_rdata_q[31:14] == '0)
      else $error("reserved read bits not zero");
   chk_share_held: assert property (hcca_wr_q && !hcca_ack |=> hcca_wr_q)
      else $error("shared area write dropped early");
   chk_flag_after_ack: assert property (clk_en && hcca_wr_q && hcca_ack |=>
      start_of_frame_flag_q && endpoint_descriptor_fetch_ok_q && !hcca_wr_q)
      else $error("flag or fetch not raised after write");
   chk_flag_sticky: assert property
      (start_of_frame_flag_q && !start_of_frame_clear |=> start_of_frame_flag_q)
      else $error("flag lost without clear");
   chk_token_pulse: assert property (sof_req_q |=> !sof_req_q)
      else $error("token request longer than one cycle");
   chk_share_after_tok: assert property ($rose(hcca_wr_q) |-> $past(sof_sent))
      else $error("shared area write before token sent");
   chk_periodic_wait: assert property
      ($rose(periodic_go_q) |-> !$past(async_xfer_busy))
      else $error("periodic priority cut a transfer short");
   chk_left_range: assert property
      (frame_time_left_q <= frame_timing_pkg::FRAME_INTERVAL_NOMINAL)
      else $error("remaining time above interval");
endmodule

bind usb_frame_counter_periodic_start frame_counter_checker i_chk (.*);

// ### frame_host_model.sv
// far side: token sender and shared memory answering the frame sequence
module frame_host_model #(parameter int ACK_DLY = 3) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sof_req_q,
   input wire logic hcca_wr_q,
   output logic sof_sent,
   output logic hcca_ack
);
   int wait_cnt;
   // token goes out the cycle after the request
   always_ff @(posedge core_clk) begin
      sof_sent <= sof_req_q && !sys_rst;
   end
   // slow memory: ack only after a few cycles, never before the token
   always_ff @(posedge core_clk) begin
      if (sys_rst || !hcca_wr_q || hcca_ack) begin
         wait_cnt <= 0;
         hcca_ack <= 1'b0;
      end else begin
         wait_cnt <= wait_cnt + 1;
         hcca_ack <= (wait_cnt == ACK_DLY - 1);
      end
   end
endmodule

// ### usb_frame_counter_periodic_start_tb_top.sv
// testbench for the frame number counter and periodic start logic
module usb_frame_counter_periodic_start_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, sys_rst, clk_en, bit_tick, operational_state;
   logic reg_wr, reg_rd, start_of_frame_clear, async_xfer_busy;
   logic [frame_timing_pkg::ADDR_W-1:0] reg_addr;
   logic [frame_timing_pkg::DATA_W-1:0] reg_wdata, reg_rdata_q;
   logic reg_rvalid_q, sof_req_q, hcca_wr_q, start_of_frame_flag_q;
   logic endpoint_descriptor_fetch_ok_q, periodic_go_q, sof_sent, hcca_ack;
   logic [frame_timing_pkg::FN_W-1:0] hcca_data_q;
   logic [frame_timing_pkg::FIELD_W-1:0] frame_time_left_q;
   int error_cnt = 0, tests_run = 0, cyc = 0, sof_last = 0, sof_gap = 0;
   int n;
   usb_frame_counter_periodic_start i_dut (.*);
   frame_host_model #(.ACK_DLY(3)) i_host (.*);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (sof_req_q === 1'b1) begin
         sof_gap <= cyc - sof_last;
         sof_last <= cyc;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      check(reg_rvalid_q, 1);
      check(reg_rdata_q, exp);
   endtask
   task automatic pulse_clear;
      @(negedge core_clk);
      start_of_frame_clear = 1'b1;
      @(negedge core_clk);
      start_of_frame_clear = 1'b0;
   endtask
   task automatic wait_flag;
      n = 0;
      while (start_of_frame_flag_q !== 1'b1 && n < 13000) begin
         @(negedge core_clk);
         n++;
      end
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      {sys_rst, clk_en, bit_tick, operational_state} = 4'b1100;
      {reg_wr, reg_rd, start_of_frame_clear, async_xfer_busy} = 4'b0000;
      reg_addr = '0;
      reg_wdata = '0;
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      // bit_tick held low so the counter cannot step under these reads
      reg_check(frame_timing_pkg::FRAME_COUNT_OFS, 32'h0);
      reg_check(frame_timing_pkg::PERIODIC_THRESHOLD_OFS, 32'h0);
      reg_write(8'h44, 32'h0000_1234);
      reg_check(8'h44, 32'h0);
      reg_write(frame_timing_pkg::PERIODIC_THRESHOLD_OFS, 32'h0000_3e67);
      reg_check(frame_timing_pkg::PERIODIC_THRESHOLD_OFS, 32'h3e67);
      // typical value lies beyond one frame, so use a reachable one
      reg_write(frame_timing_pkg::PERIODIC_THRESHOLD_OFS, 32'hffff_0064);
      reg_check(frame_timing_pkg::PERIODIC_THRESHOLD_OFS, 32'h64);
      reg_write(frame_timing_pkg::FRAME_COUNT_OFS, 32'hffff_ffff);
      reg_check(frame_timing_pkg::FRAME_COUNT_OFS, 32'h3fff);
      @(negedge core_clk);
      operational_state = 1'b1;
      @(negedge core_clk);
      bit_tick = 1'b1;
      wait_flag();
      check(start_of_frame_flag_q, 1);
      check(hcca_data_q, 32'h4000);
      check(endpoint_descriptor_fetch_ok_q, 1);
      reg_check(frame_timing_pkg::FRAME_COUNT_OFS, 32'h0);
      pulse_clear();
      check(start_of_frame_flag_q, 0);
      async_xfer_busy = 1'b1;
      n = 0;
      while (frame_time_left_q !== 14'h0064 && n < 13000) begin
         @(negedge core_clk);
         n++;
      end
      repeat (4) @(negedge core_clk);
      check(periodic_go_q, 0);
      async_xfer_busy = 1'b0;
      repeat (3) @(negedge core_clk);
      check(periodic_go_q, 1);
      for (int i = 1; i < 3; i++) begin
         wait_flag();
         check(start_of_frame_flag_q, 1);
         check(hcca_data_q, 32'h4000 + i);
         check(periodic_go_q, 0);
         pulse_clear();
      end
      check(sof_gap, 12000);
      // clock enable low must freeze the down counter
      clk_en = 1'b0;
      n = frame_time_left_q;
      repeat (5) @(negedge core_clk);
      check(frame_time_left_q, n);
      clk_en = 1'b1;
      // leaving the operational state withdraws fetch permission
      operational_state = 1'b0;
      repeat (2) @(negedge core_clk);
      check(endpoint_descriptor_fetch_ok_q, 0);
      // mid-run reset; ticks stopped so the count cannot step
      sys_rst = 1'b1;
      bit_tick = 1'b0;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      reg_check(frame_timing_pkg::PERIODIC_THRESHOLD_OFS, 32'h0);
      reg_check(frame_timing_pkg::FRAME_COUNT_OFS, 32'h0);
      check(start_of_frame_flag_q, 0);
      tally_and_finish();
   end
endmodule
